// [rtl/fbs_pkg.sv]
// Package for the boundary-scan test access port of the 36-bit FIFO.
// Assumes a single system clock that oversamples the test clock.
package fbs_pkg;
    localparam int FBS_IR_WIDTH = 4;
    localparam int FBS_DATA_WIDTH = 36;
    localparam int FBS_IDCODE_WIDTH = 32;
    // Identification value is arbitrary.
    localparam logic [31:0] FBS_IDCODE_RST = 32'h0000_0001;
    localparam logic [3:0] FBS_IR_RST = 4'h1;
    localparam logic [3:0] FBS_IR_CAPTURE = 4'h1;
    localparam logic [3:0] FBS_OP_IDCODE = 4'h1;
    localparam logic [3:0] FBS_OP_BYPASS = 4'hf;
    localparam int FBS_SYNC_STAGES = 2;

    typedef enum logic [15:0] {
        FBS_RESET = 16'h0001,
        FBS_IDLE = 16'h0002,
        FBS_SEL_DR = 16'h0004,
        FBS_CAP_DR = 16'h0008,
        FBS_SH_DR = 16'h0010,
        FBS_EX1_DR = 16'h0020,
        FBS_PA_DR = 16'h0040,
        FBS_EX2_DR = 16'h0080,
        FBS_UPD_DR = 16'h0100,
        FBS_SEL_IR = 16'h0200,
        FBS_CAP_IR = 16'h0400,
        FBS_SH_IR = 16'h0800,
        FBS_EX1_IR = 16'h1000,
        FBS_PA_IR = 16'h2000,
        FBS_EX2_IR = 16'h4000,
        FBS_UPD_IR = 16'h8000
    } fbs_state_t;
endpackage

// [rtl/fbs_sync.sv]
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level is stable for several clock periods.
`timescale 1ns/1ps
`default_nettype none
module fbs_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [rtl/fbs_tap.sv]
// Test access port controller of the FIFO, oversampling the test clock.
// Assumes clk runs much faster than the test clock, which is a sampled input.
// Overview of operation
// RULE_01 - Mode select and test data in are taken on each test clock rise.
// RULE_02 - Test data out changes on test clock fall from selected register.
// RULE_03 - Serial data shifts into instruction, identification or bypass register.
// RULE_04 - Test data out is driven only in shift data or shift instruction state.
// RULE_05 - State moves only as mode select dictates.
// RULE_06 - Test reset input resets the controller at once, clock independent.
// RULE_07 - No power-up reset; five high mode select cycles reach reset state.
// RULE_08 - FIFO data outputs stay high impedance until the controller was reset.
// RULE_09 - Unconnected mode select or test data in reads as high.
// RULE_10 - Without test reset, the system may tie it to the FIFO master reset.
// RULE_11 - Sixteen-state controller; identification register selected after reset.
`timescale 1ns/1ps
`default_nettype none
module fbs_tap
    import fbs_pkg::*;
#(
    parameter int IR_WIDTH = fbs_pkg::FBS_IR_WIDTH,
    parameter int DATA_WIDTH = fbs_pkg::FBS_DATA_WIDTH,
    parameter logic [31:0] IDCODE = fbs_pkg::FBS_IDCODE_RST
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst,
    input wire logic fifo_oe_n,
    output logic tdo_o,
    output logic tdo_oe_n,
    output logic fifo_q_oe_n
);
    import fbs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers. Pins are resolved to high when floating by the pad
    // pull-up, so a released pin arrives here as one.
    logic tck_s, tms_s, tdi_s, tck_s_q;
    logic fifo_oe_n_s;

    fbs_sync #(.RST_VAL(1'b0)) u_tck (.clk(clk), .reset(reset), .d(tck), .q(tck_s));
    fbs_sync #(.RST_VAL(1'b1)) u_tms (.clk(clk), .reset(reset), .d(tms), .q(tms_s)); // RULE_09
    fbs_sync #(.RST_VAL(1'b1)) u_tdi (.clk(clk), .reset(reset), .d(tdi), .q(tdi_s)); // RULE_09

    // The output enable is a pin as well. It rests at disabled while the
    // synchroniser fills, so the FIFO outputs never glitch on after reset.
    fbs_sync #(.RST_VAL(1'b1)) u_oe (
        .clk(clk),
        .reset(reset),
        .d(fifo_oe_n),
        .q(fifo_oe_n_s)
    );

    // The test reset acts without any clock edge; it is not synchronised so
    // it works even with clk-derived edges absent, trading glitch immunity.
    wire logic trst_any = trst | reset;

    // Edges are found on the synchronised test clock. A high or low phase
    // shorter than a few clk periods may be missed, which bounds its rate.
    always_ff @(posedge clk) begin
        if (reset) begin
            tck_s_q <= 1'b0;
        end else begin
            tck_s_q <= tck_s;
        end
    end

    wire logic tck_rise = tck_s & ~tck_s_q; // RULE_01
    wire logic tck_fall = ~tck_s & tck_s_q; // RULE_02

    ////////////////////////////////////////////////////////////////////////////
    // Controller state.
    fbs_state_t state_q, state_d;
    logic was_reset_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q) // RULE_05 RULE_11
            FBS_RESET: state_d = tms_s ? FBS_RESET : FBS_IDLE;
            FBS_IDLE: state_d = tms_s ? FBS_SEL_DR : FBS_IDLE;
            FBS_SEL_DR: state_d = tms_s ? FBS_SEL_IR : FBS_CAP_DR;
            FBS_CAP_DR: state_d = tms_s ? FBS_EX1_DR : FBS_SH_DR;
            FBS_SH_DR: state_d = tms_s ? FBS_EX1_DR : FBS_SH_DR;
            FBS_EX1_DR: state_d = tms_s ? FBS_UPD_DR : FBS_PA_DR;
            FBS_PA_DR: state_d = tms_s ? FBS_EX2_DR : FBS_PA_DR;
            FBS_EX2_DR: state_d = tms_s ? FBS_UPD_DR : FBS_SH_DR;
            FBS_UPD_DR: state_d = tms_s ? FBS_SEL_DR : FBS_IDLE;
            FBS_SEL_IR: state_d = tms_s ? FBS_RESET : FBS_CAP_IR; // RULE_07
            FBS_CAP_IR: state_d = tms_s ? FBS_EX1_IR : FBS_SH_IR;
            FBS_SH_IR: state_d = tms_s ? FBS_EX1_IR : FBS_SH_IR;
            FBS_EX1_IR: state_d = tms_s ? FBS_UPD_IR : FBS_PA_IR;
            FBS_PA_IR: state_d = tms_s ? FBS_EX2_IR : FBS_PA_IR;
            FBS_EX2_IR: state_d = tms_s ? FBS_UPD_IR : FBS_SH_IR;
            FBS_UPD_IR: state_d = tms_s ? FBS_SEL_DR : FBS_IDLE;
            default: state_d = FBS_RESET;
        endcase
    end

    // The system reset stands in for power-up. It leaves the controller in
    // idle, not in test-logic-reset, because the port must not reset itself:
    // only the test reset, or mode select held high on rising test clock
    // edges, brings it to reset and lets the FIFO outputs come on.
    always_ff @(posedge clk or posedge trst) begin
        if (trst) begin
            state_q <= FBS_RESET; // RULE_06 RULE_10
        end else if (reset) begin
            state_q <= FBS_IDLE; // RULE_07
        end else if (tck_rise) begin
            state_q <= state_d; // RULE_01
        end
    end

    // Reset-seen flag. The test reset sets it at once and wins over the
    // system reset; a rising test clock edge in test-logic-reset sets it too.

    always_ff @(posedge clk or posedge trst) begin
        if (trst) begin
            was_reset_q <= 1'b1; // RULE_06
        end else if (reset) begin
            was_reset_q <= 1'b0; // RULE_07
        end else if (tck_rise && state_q == FBS_RESET) begin
            was_reset_q <= 1'b1; // RULE_07
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction, identification and bypass registers.
    // All stages move only on a detected rising test clock edge, so the
    // system clock may run at any rate well above the test clock.
    logic [IR_WIDTH-1:0] ir_sh_q, ir_q;
    logic [31:0] id_sh_q;
    logic byp_q;

    // One-hot decodes of the states that the data path acts on. Only one of
    // them is true at a time, so the stages below never compete.
    wire logic in_reset = (state_q == FBS_RESET);
    wire logic in_cap_dr = (state_q == FBS_CAP_DR);
    wire logic in_sh_dr = (state_q == FBS_SH_DR);
    wire logic in_cap_ir = (state_q == FBS_CAP_IR);
    wire logic in_sh_ir = (state_q == FBS_SH_IR);
    wire logic in_upd_ir = (state_q == FBS_UPD_IR);

    // Any opcode but the identification one selects the bypass stage.
    wire logic sel_id = (ir_q == IR_WIDTH'(FBS_OP_IDCODE));
    wire logic sh_id = in_sh_dr & sel_id;
    wire logic sh_byp = in_sh_dr & ~sel_id;

    // Instruction shift stage: loads the fixed capture pattern, then shifts
    // one bit per rising test clock edge, least significant bit out first.
    always_ff @(posedge clk or posedge trst_any) begin
        if (trst_any) begin
            ir_sh_q <= '0;
        end else if (tck_rise && in_cap_ir) begin
            ir_sh_q <= IR_WIDTH'(FBS_IR_CAPTURE);
        end else if (tck_rise && in_sh_ir) begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_WIDTH-1:1]}; // RULE_03
        end
    end

    // Active instruction. Only update-IR loads the shift stage into it, so a scan that is held
    // in pause-IR never applies a half-shifted opcode.
    always_ff @(posedge clk or posedge trst_any) begin
        if (trst_any) begin
            ir_q <= IR_WIDTH'(FBS_IR_RST); // RULE_11
        end else if (tck_rise && in_reset) begin
            ir_q <= IR_WIDTH'(FBS_IR_RST); // RULE_11
        end else if (tck_rise && in_upd_ir) begin
            ir_q <= ir_sh_q;
        end
    end

    // Identification stage: loaded at capture-DR, shifted out LSB first.
    always_ff @(posedge clk or posedge trst_any) begin
        if (trst_any) begin
            id_sh_q <= '0;
        end else if (tck_rise && in_cap_dr) begin
            id_sh_q <= IDCODE;
        end else if (tck_rise && sh_id) begin
            id_sh_q <= {tdi_s, id_sh_q[31:1]}; // RULE_03
        end
    end

    // Bypass stage: a single flop, cleared at capture-DR.
    always_ff @(posedge clk or posedge trst_any) begin
        if (trst_any) begin
            byp_q <= 1'b0;
        end else if (tck_rise && in_cap_dr) begin
            byp_q <= 1'b0;
        end else if (tck_rise && sh_byp) begin
            byp_q <= tdi_s; // RULE_03
        end
    end

    // The serial output follows the stage of the current shift state.
    wire logic dr_bit = sel_id ? id_sh_q[0] : byp_q;
    wire logic tdo_bit = in_sh_ir ? ir_sh_q[0] : dr_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Test data output and its enable, changed only on the falling test clock edge.
    always_ff @(posedge clk or posedge trst_any) begin
        if (trst_any) begin
            tdo_o <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            tdo_o <= tdo_bit; // RULE_02
            tdo_oe_n <= ~(in_sh_dr | in_sh_ir); // RULE_04
        end
    end

    // The FIFO outputs stay off until a real TAP reset has been seen; the
    // system reset counts as power-up and so keeps them off as well.
    always_ff @(posedge clk) begin
        if (reset) begin
            fifo_q_oe_n <= 1'b1;
        end else begin
            fifo_q_oe_n <= fifo_oe_n_s | ~was_reset_q; // RULE_08
        end
    end
endmodule
`default_nettype wire

// [tb/fbs_tap_assertions.sv]
// Concurrent checks on the ports of the test access port.
// Assumes tck is much slower than clk and is bound to every fbs_tap.
`timescale 1ns/1ps
`default_nettype none
module fbs_tap_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst,
    input wire logic fifo_oe_n,
    input wire logic tdo_o,
    input wire logic tdo_oe_n,
    input wire logic fifo_q_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Eight low samples lie well past the output update that follows a fall.
    sequence s_tck_low;
        (!tck && !trst) [*8];
    endsequence
    sequence s_trst_en;
        (trst && !fifo_oe_n) [*3];
    endsequence
    a_tdo_late_stable: assert property (s_tck_low |-> $stable(tdo_o) && $stable(tdo_oe_n))
        else $error("tdo moved late in tck low");
    a_tdo_move_low: assert property (!$stable(tdo_o) && !trst |-> !tck)
        else $error("tdo moved while tck high");
    a_oe_on_low: assert property ($fell(tdo_oe_n) |-> !tck)
        else $error("tdo enabled while tck high");
    a_trst_oe_off: assert property (trst |-> tdo_oe_n)
        else $error("tdo driven during trst");
    a_sysrst_idle: assert property ($fell(reset) |-> tdo_oe_n && fifo_q_oe_n)
        else $error("outputs active after reset");
    a_trst_fifo_on: assert property (s_trst_en |=> !fifo_q_oe_n)
        else $error("fifo outputs off after trst");
    a_fifo_oe_off: assert property (fifo_oe_n [*4] |-> fifo_q_oe_n)
        else $error("fifo outputs on while disabled");
    a_tdo_off_trst: assert property ($fell(trst) |-> tdo_oe_n ##1 tdo_oe_n)
        else $error("tdo driven after trst");
endmodule
`default_nettype wire
bind fbs_tap fbs_tap_assertions u_chk (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .trst(trst), .fifo_oe_n(fifo_oe_n), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n),
    .fifo_q_oe_n(fifo_q_oe_n));

// [tb/fbs_jtag_host.sv]
// Model of the external test controller driving the scan pins.
// Assumes clk is the bench clock; tck stands low between steps.
`timescale 1ns/1ps
`default_nettype none
module fbs_jtag_host (
    input wire logic clk,
    input wire logic tdo_o,
    input wire logic tdo_oe_n,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst
);
    // Idle tms and tdi rest high as the pull-ups would leave them; tck and trst rest low.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst = 1'b0;
    end
    // One tck period of 25 clk; tdo is read at the end of the low half.
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (12) @(posedge clk);
        o = tdo_oe_n ? 1'bz : tdo_o;
        tck <= 1'b1;
        repeat (12) @(posedge clk);
        tck <= 1'b0;
    endtask
    task automatic pulse_trst();
        trst <= 1'b1;
        repeat (3) @(posedge clk);
        trst <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/fbs_tap_tb.sv]
// Self-checking bench for the test access port.
// Assumes the host model owns every scan pin.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module fbs_tap_tb;
    import fbs_pkg::*;
    logic clk = 1'b0, reset = 1'b1, fifo_oe_n = 1'b0, tck, tms, tdi, trst;
    logic tdo_o, tdo_oe_n, fifo_q_oe_n, o;
    logic [31:0] dout;
    int err_total = 0, checks = 0;
    always #2.5 clk = ~clk;
    fbs_tap DUT (.clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
        .fifo_oe_n(fifo_oe_n), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .fifo_q_oe_n(fifo_q_oe_n));
    fbs_jtag_host host (.clk(clk), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms),
        .tdi(tdi), .trst(trst));
    //////////////////////////////////////////////////////////////////////
    // Scan from idle back to idle, shifting n bits LSB first.
    task automatic scan(input logic ir, input logic [31:0] din, input int n);
        dout = '0;
        host.step(1'b1, 1'b1, o);
        if (ir) host.step(1'b1, 1'b1, o);
        host.step(1'b0, 1'b1, o);
        host.step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            host.step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        host.step(1'b1, 1'b1, o);
        host.step(1'b0, 1'b1, o);
    endtask
    task automatic t_tms_reset();
        `CHK("fifo_q_oe_n", 1'b1, fifo_q_oe_n)
        repeat (2) host.step(1'b1, 1'b1, o);
        `CHK("fifo_q_oe_n", 1'b1, fifo_q_oe_n)
        repeat (3) host.step(1'b1, 1'b1, o);
        host.step(1'b0, 1'b1, o);
        `CHK("fifo_q_oe_n", 1'b0, fifo_q_oe_n)
        scan(1'b0, 32'h0, 32);
        `CHK("idcode", FBS_IDCODE_RST, dout)
        `CHK("tdo_oe_n", 1'b1, tdo_oe_n)
        $display("t_tms_reset done");
    endtask
    task automatic t_bypass();
        scan(1'b1, {28'h0, FBS_OP_BYPASS}, 4);
        `CHK("ir capture", {28'h0, FBS_IR_CAPTURE}, dout)
        scan(1'b0, 32'hb5, 8);
        `CHK("bypass", 32'h6a, dout)
        $display("t_bypass done");
    endtask
    task automatic t_trst();
        @(posedge clk) reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("fifo_q_oe_n", 1'b1, fifo_q_oe_n)
        host.pulse_trst();
        repeat (2) @(posedge clk);
        `CHK("fifo_q_oe_n", 1'b0, fifo_q_oe_n)
        fifo_oe_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("fifo_q_oe_n", 1'b1, fifo_q_oe_n)
        host.step(1'b0, 1'b1, o);
        scan(1'b0, 32'h0, 32);
        `CHK("idcode", FBS_IDCODE_RST, dout)
        $display("t_trst done");
    endtask
    // Test reset wired to the FIFO master reset, as a system without its own
    // test reset line would do.
    task automatic t_tied_reset();
        fifo_oe_n <= 1'b0;
        @(posedge clk) reset <= 1'b1;
        host.pulse_trst();
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("fifo_q_oe_n", 1'b0, fifo_q_oe_n)
        `CHK("tdo_oe_n", 1'b1, tdo_oe_n)
        $display("t_tied_reset done");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_tms_reset();
        t_bypass();
        t_trst();
        t_tied_reset();
        conclude();
    end
    initial begin
        #300us;
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
